// ===== reset_cop_pkg.sv
// Functional notes
// - every reset sets flags of active sources and clears flags of inactive ones, except that low-voltage reset keeps bit 7
// - a debug forced reset alone leaves every status flag cleared
// - outside window mode any write to the status address restarts the watchdog; flags stay unchanged
// - power-on sets bit 7 and bit 1, all other status bits cleared
// - low-voltage reset keeps bit 7, sets bit 1, clears the rest
// - external pin low level sets bit 6
// - watchdog timeout sets bit 5; never happens while watchdog disabled
// - illegal opcode, disabled stop or disabled background instruction resets, sets bit 4
// - loss of external clock sets bit 2
// - low-voltage trip resets only with both reset and stop-detect enables; sets bit 1
// - debug write of 1 to bit 0 of force register causes full reset
// - user program writes to force register are ignored; debug port only
// - force register always reads zero
// - options one register readable always, only first write after reset taken
// - options one bits 3 and 2 always read zero
// - stop enable resets to 0; stop while disabled is an illegal opcode reset
// - timeout field with clock select picks period; code 00 disables watchdog
// - oscillator clock codes 01, 10, 11 overflow after 2^5, 2^8, 2^10 ticks
// - bus clock overflow 2^13, 2^16, 2^18; window opens at 6144, 49152, 196608
// - window mode restart is write 0x55 then 0xAA; early write resets
// - clock select 0 picks the 1 kHz oscillator, 1 the bus clock
package reset_cop_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LPO_PERIOD_NS = 1000000;
  localparam int LPO_DIV_CYCLES = LPO_PERIOD_NS / CLK_PERIOD_NS;
  localparam int WDOG_CNT_W = 18;
  // register indices on the register port
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_FORCE = 2'h1;
  localparam logic [1:0] ADDR_OPT1 = 2'h2;
  localparam logic [1:0] ADDR_OPT2 = 2'h3;
  // status bit positions
  localparam int STAT_POWER_ON = 7;
  localparam int STAT_PIN = 6;
  localparam int STAT_WDOG = 5;
  localparam int STAT_ILLEGAL = 4;
  localparam int STAT_CLK_LOSS = 2;
  localparam int STAT_LOW_VOLT = 1;
  localparam logic [7:0] STATUS_POR_VALUE = 8'h82;
  localparam int FORCE_BIT = 0;
  // options one layout
  localparam int OPT1_TIMEOUT_LO = 6;
  localparam int OPT1_STOP = 5;
  localparam logic [7:0] OPT1_RESET = 8'hC0;
  localparam logic [7:0] OPT1_MASK = 8'hE0;
  // options two layout
  localparam int OPT2_CLKSEL = 7;
  localparam int OPT2_WINDOW = 6;
  localparam logic [7:0] OPT2_RESET = 8'h00;
  localparam logic [7:0] OPT2_MASK = 8'hC0;
  // window restart keys
  localparam logic [7:0] WIN_KEY_FIRST = 8'h55;
  localparam logic [7:0] WIN_KEY_SECOND = 8'hAA;
  // overflow and window counts
  localparam int LPO_OVF_1 = 32;
  localparam int LPO_OVF_2 = 256;
  localparam int LPO_OVF_3 = 1024;
  localparam int BUS_OVF_1 = 8192;
  localparam int BUS_OVF_2 = 65536;
  localparam int BUS_OVF_3 = 262144;
  localparam int BUS_WIN_1 = 6144;
  localparam int BUS_WIN_2 = 49152;
  localparam int BUS_WIN_3 = 196608;

  typedef enum logic [1:0] {
    WD_OFF = 2'b00,
    WD_SHORT = 2'b01,
    WD_MID = 2'b10,
    WD_LONG = 2'b11
  } wd_timeout_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ARMED = 2'b01
  } win_seq_t;
endpackage

// ===== watchdog_if.sv
`timescale 1ns/1ps
interface watchdog_if;
  import reset_cop_pkg::*;
  logic clk_sel;
  logic window_mode;
  wd_timeout_t timeout;
  logic restart;
  logic window_open;
  logic expired;
  modport ctrl (output clk_sel, output window_mode, output timeout, output restart,
                input window_open, input expired);
  modport timer (input clk_sel, input window_mode, input timeout, input restart,
                 output window_open, output expired);
endinterface // watchdog_if

// ===== write_once_reg.sv
`timescale 1ns/1ps
module write_once_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0,
  parameter logic [W-1:0] WRITE_MASK = '1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  // write side
  input wire logic wr,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic written;
  wire take = wr & ~written & ~clear;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= RESET_VAL;
      written <= 1'b0;
    end
    else if (clear)
    begin
      q <= RESET_VAL;
      written <= 1'b0;
    end
    else if (take)
    begin
      q <= d & WRITE_MASK;
      written <= 1'b1;
    end
  end
endmodule // write_once_reg

// ===== watchdog_timer.sv
`timescale 1ns/1ps
module watchdog_timer
  import reset_cop_pkg::*;
#(
  parameter int LPO_DIV = LPO_DIV_CYCLES,
  parameter int B_OVF_1 = BUS_OVF_1,
  parameter int B_OVF_2 = BUS_OVF_2,
  parameter int B_OVF_3 = BUS_OVF_3,
  parameter int B_WIN_1 = BUS_WIN_1,
  parameter int B_WIN_2 = BUS_WIN_2,
  parameter int B_WIN_3 = BUS_WIN_3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control side
  watchdog_if.timer wd
);
  localparam int DW = $clog2(LPO_DIV + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(LPO_DIV - 1);
  localparam logic [WDOG_CNT_W-1:0] L1 = WDOG_CNT_W'(LPO_OVF_1 - 1);
  localparam logic [WDOG_CNT_W-1:0] L2 = WDOG_CNT_W'(LPO_OVF_2 - 1);
  localparam logic [WDOG_CNT_W-1:0] L3 = WDOG_CNT_W'(LPO_OVF_3 - 1);
  localparam logic [WDOG_CNT_W-1:0] B1 = WDOG_CNT_W'(B_OVF_1 - 1);
  localparam logic [WDOG_CNT_W-1:0] B2 = WDOG_CNT_W'(B_OVF_2 - 1);
  localparam logic [WDOG_CNT_W-1:0] B3 = WDOG_CNT_W'(B_OVF_3 - 1);
  localparam logic [WDOG_CNT_W-1:0] W1 = WDOG_CNT_W'(B_WIN_1);
  localparam logic [WDOG_CNT_W-1:0] W2 = WDOG_CNT_W'(B_WIN_2);
  localparam logic [WDOG_CNT_W-1:0] W3 = WDOG_CNT_W'(B_WIN_3);

  logic [DW-1:0] div;
  logic lpo_tick;
  logic [WDOG_CNT_W-1:0] count;
  logic expired_q;

  // 1 kHz oscillator tick derived from the core clock
  wire div_wrap = (div == DIV_LAST);
  wire enabled = (wd.timeout != WD_OFF);
  wire tick = wd.clk_sel ? 1'b1 : lpo_tick;
  wire [WDOG_CNT_W-1:0] lpo_last = (wd.timeout == WD_SHORT) ? L1 :
                                   (wd.timeout == WD_MID) ? L2 : L3;
  wire [WDOG_CNT_W-1:0] bus_last = (wd.timeout == WD_SHORT) ? B1 :
                                   (wd.timeout == WD_MID) ? B2 : B3;
  wire [WDOG_CNT_W-1:0] win_first = (wd.timeout == WD_SHORT) ? W1 :
                                    (wd.timeout == WD_MID) ? W2 : W3;
  wire [WDOG_CNT_W-1:0] last = wd.clk_sel ? bus_last : lpo_last;
  wire at_last = (count == last);
  wire overflow = enabled & tick & at_last & ~wd.restart;
  wire [WDOG_CNT_W-1:0] next_count = wd.restart ? '0 :
                                     (~enabled | ~tick) ? count :
                                     at_last ? '0 : count + 1'b1;

  // outside window mode every restart is in the window
  assign wd.window_open = ~wd.window_mode | (count >= win_first);
  assign wd.expired = expired_q;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div <= '0;
      lpo_tick <= 1'b0;
    end
    else
    begin
      div <= div_wrap ? '0 : div + 1'b1;
      lpo_tick <= div_wrap;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      expired_q <= 1'b0;
    end
    else
    begin
      count <= next_count;
      expired_q <= overflow;
    end
  end
endmodule // watchdog_timer

// ===== reset_source_and_cop_watchdog.sv
`timescale 1ns/1ps
module reset_source_and_cop_watchdog
  import reset_cop_pkg::*;
#(
  parameter int LPO_DIV = LPO_DIV_CYCLES,
  parameter int B_OVF_1 = BUS_OVF_1,
  parameter int B_OVF_2 = BUS_OVF_2,
  parameter int B_OVF_3 = BUS_OVF_3,
  parameter int B_WIN_1 = BUS_WIN_1,
  parameter int B_WIN_2 = BUS_WIN_2,
  parameter int B_WIN_3 = BUS_WIN_3
) (
  // clock and power-on reset
  input wire logic core_clk,
  input wire logic rst,
  // cpu register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // serial background debug write port
  input wire logic dbg_wr,
  input wire logic [1:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  // reset sources
  input wire logic reset_pin_n,
  input wire logic clock_lost,
  input wire logic low_voltage_trip,
  input wire logic low_voltage_reset_enable,
  input wire logic low_voltage_stop_enable,
  input wire logic opcode_unimplemented,
  input wire logic stop_executed,
  input wire logic background_executed,
  input wire logic background_mode_enable,
  // system outputs
  output logic sys_reset,
  output logic stop_mode_allowed,
  output logic watchdog_running
);
  logic [7:0] status;
  logic [7:0] opt1;
  logic [7:0] opt2;
  win_seq_t seq;
  win_seq_t next_seq;
  watchdog_if wd ();

  // register port and debug port decode
  wire wr_status = reg_wr & (reg_addr == ADDR_STATUS);
  wire wr_opt1 = reg_wr & (reg_addr == ADDR_OPT1);
  wire wr_opt2 = reg_wr & (reg_addr == ADDR_OPT2);
  wire force_req = dbg_wr & (dbg_addr == ADDR_FORCE) & dbg_wdata[FORCE_BIT];

  // configuration fields
  wire stop_en = opt1[OPT1_STOP];
  wire [1:0] timeout_code = opt1[OPT1_TIMEOUT_LO +: 2];
  wire wd_on = (timeout_code != 2'b00);
  wire window_active = wd_on & opt2[OPT2_CLKSEL] & opt2[OPT2_WINDOW];

  // window restart sequence
  wire early_write = wr_status & window_active & ~wd.window_open;
  wire key_first = wr_status & (reg_wdata == WIN_KEY_FIRST);
  wire key_second = wr_status & (reg_wdata == WIN_KEY_SECOND) & (seq == SEQ_ARMED);
  wire win_restart = window_active & wd.window_open & key_second;
  wire plain_restart = wr_status & ~window_active;

  // reset sources sampled this cycle
  wire src_pin = ~reset_pin_n;
  wire src_loc = clock_lost;
  wire src_lvd = low_voltage_trip & low_voltage_reset_enable
                 & low_voltage_stop_enable;
  wire src_illegal_opcode_flag = opcode_unimplemented | (stop_executed & ~stop_en)
                  | (background_executed & ~background_mode_enable);
  wire src_wdog = wd.expired | early_write;
  wire any_src = src_pin | src_loc | src_lvd | src_illegal_opcode_flag | src_wdog | force_req;

  // a forced reset alone leaves all flags clear
  wire [7:0] next_status = {src_lvd ? status[STAT_POWER_ON] : 1'b0, src_pin, src_wdog,
                            src_illegal_opcode_flag, 1'b0, src_loc, src_lvd, 1'b0};

  wire [7:0] next_rdata = (reg_addr == ADDR_STATUS) ? status :
                          (reg_addr == ADDR_OPT1) ? (opt1 & OPT1_MASK) :
                          (reg_addr == ADDR_OPT2) ? (opt2 & OPT2_MASK) :
                          8'h00;

  assign wd.clk_sel = opt2[OPT2_CLKSEL];
  assign wd.window_mode = opt2[OPT2_WINDOW];
  assign wd.timeout = wd_timeout_t'(timeout_code);
  assign wd.restart = sys_reset | plain_restart | win_restart;

  always_comb
  begin
    next_seq = seq;
    case (seq)
      SEQ_IDLE:
      begin
        if (key_first)
          next_seq = SEQ_ARMED;
      end
      SEQ_ARMED:
      begin
        if (wr_status & ~key_first)
          next_seq = SEQ_IDLE;
      end
      default:
        next_seq = SEQ_IDLE;
    endcase
    if (sys_reset | ~window_active)
      next_seq = SEQ_IDLE;
  end

  write_once_reg #(
    .W(8),
    .RESET_VAL(OPT1_RESET),
    .WRITE_MASK(OPT1_MASK)
  ) u_opt1 (
    .core_clk(core_clk),
    .rst(rst),
    .clear(sys_reset),
    .wr(wr_opt1),
    .d(reg_wdata),
    .q(opt1)
  );

  write_once_reg #(
    .W(8),
    .RESET_VAL(OPT2_RESET),
    .WRITE_MASK(OPT2_MASK)
  ) u_opt2 (
    .core_clk(core_clk),
    .rst(rst),
    .clear(sys_reset),
    .wr(wr_opt2),
    .d(reg_wdata),
    .q(opt2)
  );

  watchdog_timer #(
    .LPO_DIV(LPO_DIV),
    .B_OVF_1(B_OVF_1),
    .B_OVF_2(B_OVF_2),
    .B_OVF_3(B_OVF_3),
    .B_WIN_1(B_WIN_1),
    .B_WIN_2(B_WIN_2),
    .B_WIN_3(B_WIN_3)
  ) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .wd(wd)
  );

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      status <= STATUS_POR_VALUE;
    else if (any_src)
      status <= next_status;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sys_reset <= 1'b0;
      seq <= SEQ_IDLE;
    end
    else
    begin
      sys_reset <= any_src;
      seq <= next_seq;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      stop_mode_allowed <= 1'b0;
      watchdog_running <= 1'b0;
    end
    else
    begin
      if (reg_rd)
        reg_rdata <= next_rdata;
      stop_mode_allowed <= stop_en;
      watchdog_running <= wd_on;
    end
  end
endmodule // reset_source_and_cop_watchdog

// ===== reset_cop_properties.sv
`timescale 1ns/1ps
module reset_cop_properties
  import reset_cop_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register and debug ports
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic dbg_wr,
  input wire logic [1:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  // reset sources and outputs
  input wire logic reset_pin_n,
  input wire logic clock_lost,
  input wire logic low_voltage_trip,
  input wire logic low_voltage_reset_enable,
  input wire logic low_voltage_stop_enable,
  input wire logic opcode_unimplemented,
  input wire logic stop_executed,
  input wire logic background_executed,
  input wire logic background_mode_enable,
  input wire logic sys_reset,
  input wire logic stop_mode_allowed,
  input wire logic watchdog_running
);
  wire logic force_req = dbg_wr && dbg_addr == ADDR_FORCE && dbg_wdata[FORCE_BIT];
  wire logic lv_req = low_voltage_trip && low_voltage_reset_enable && low_voltage_stop_enable;
  wire logic any_src = !reset_pin_n || clock_lost || opcode_unimplemented || stop_executed
    || background_executed || lv_req || force_req;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_force; force_req |=> sys_reset; endproperty
  a_force: assert property (p_force) else $error("forced reset missing");
  property p_pin; !reset_pin_n |=> sys_reset; endproperty
  a_pin: assert property (p_pin) else $error("pin reset missing");
  property p_loss; clock_lost |=> sys_reset; endproperty
  a_loss: assert property (p_loss) else $error("clock loss reset missing");
  property p_illegal_opcode_flag;
    opcode_unimplemented || (background_executed && !background_mode_enable) |=> sys_reset;
  endproperty
  a_illegal_opcode_flag: assert property (p_illegal_opcode_flag) else $error("illegal opcode reset missing");
  // the registered stop enable one cycle later shows the enable seen with the stop
  property p_stop; stop_executed ##1 !stop_mode_allowed |-> sys_reset; endproperty
  a_stop: assert property (p_stop) else $error("stop reset missing");
  property p_lvr; lv_req |=> sys_reset; endproperty
  a_lvr: assert property (p_lvr) else $error("low voltage reset missing");
  property p_quiet;
    (!any_src && !watchdog_running) ##1 !watchdog_running |-> !sys_reset;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reset without source");
  property p_frd; reg_rd && reg_addr == ADDR_FORCE |=> reg_rdata == 8'h00; endproperty
  a_frd: assert property (p_frd) else $error("force register read not zero");
  property p_o1rd; reg_rd && reg_addr == ADDR_OPT1 |=> reg_rdata[4:0] == 5'h00; endproperty
  a_o1rd: assert property (p_o1rd) else $error("options low bits not zero");
  c_force: cover property (force_req);
  c_wdog: cover property (watchdog_running ##1 sys_reset);
  c_cpu_force: cover property (reg_wr && reg_addr == ADDR_FORCE);
endmodule // reset_cop_properties

bind reset_source_and_cop_watchdog reset_cop_properties u_reset_cop_properties (.*);

// ===== debug_host.sv
`timescale 1ns/1ps
module debug_host
  import reset_cop_pkg::*;
(
  // clock
  input wire logic core_clk,
  // serial background write port
  output logic dbg_wr,
  output logic [1:0] dbg_addr,
  output logic [7:0] dbg_wdata
);
  initial
  begin
    dbg_wr = 1'b0;
    dbg_addr = 2'h2;
    dbg_wdata = 8'hA5;
  end
  // one serial write command; lines are scrambled once released
  task automatic send(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    dbg_wr = 1'b1;
    dbg_addr = a;
    dbg_wdata = d;
    @(posedge core_clk);
    #1;
    dbg_wr = 1'b0;
    dbg_addr = ~a;
    dbg_wdata = ~d;
  endtask
endmodule // debug_host

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import reset_cop_pkg::*;
  localparam int OVF1 = 64;
  localparam int WIN1 = 48;
  localparam int DIV = 4;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] reg_addr = 2'h0, dbg_addr;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, dbg_wdata, rd_val;
  logic dbg_wr, sys_reset, stop_mode_allowed, watchdog_running;
  logic reset_pin_n = 1'b1, clock_lost = 1'b0, low_voltage_trip = 1'b0;
  logic low_voltage_reset_enable = 1'b1, low_voltage_stop_enable = 1'b1;
  logic opcode_unimplemented = 1'b0, stop_executed = 1'b0;
  logic background_executed = 1'b0, background_mode_enable = 1'b0;
  int fail_count = 0, checked = 0, cyc = 0, n;
  always #5 core_clk = ~core_clk;
  reset_source_and_cop_watchdog #(.LPO_DIV(DIV), .B_OVF_1(OVF1), .B_OVF_2(128),
    .B_OVF_3(256), .B_WIN_1(WIN1), .B_WIN_2(96), .B_WIN_3(192))
    u_reset_source_and_cop_watchdog (.*);
  debug_host u_debug_host (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rdchk(input logic [1:0] a, input logic [7:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    rd_val = reg_rdata;
    tick(1);
    chk(rd_val, e);
  endtask
  // cycles until the system reset rises, then ride it out
  task automatic wait_rst(input int lim, output int k);
    k = 0;
    while (sys_reset !== 1'b1 && k < lim)
    begin
      tick(1);
      k++;
    end
    while (sys_reset === 1'b1)
      tick(1);
  endtask
  task automatic src(input int s, input logic [7:0] e);
    case (s)
      0: reset_pin_n = 1'b0;
      1: clock_lost = 1'b1;
      2: opcode_unimplemented = 1'b1;
      3: stop_executed = 1'b1;
      4: background_executed = 1'b1;
      5: low_voltage_trip = 1'b1;
      default: {reset_pin_n, clock_lost} = 2'b01;
    endcase
    tick(1);
    {reset_pin_n, clock_lost, opcode_unimplemented} = 3'h4;
    {stop_executed, background_executed, low_voltage_trip} = 3'h0;
    wait_rst(4, n);
    chk(8'(n), 8'h00);
    rdchk(ADDR_STATUS, e);
  endtask
  task automatic t_por;
    rdchk(ADDR_STATUS, STATUS_POR_VALUE);
    rdchk(ADDR_OPT1, OPT1_RESET);
    chk(8'(stop_mode_allowed), 8'h00);
    chk(8'(watchdog_running), 8'h01);
    rdchk(ADDR_FORCE, 8'h00);
    src(5, 8'h82);
    $display("t_por done");
  endtask
  task automatic t_src;
    src(0, 8'h40);
    src(5, 8'h02);
    src(1, 8'h04);
    src(2, 8'h10);
    src(3, 8'h10);
    src(4, 8'h10);
    src(6, 8'h44);
    wr(ADDR_STATUS, 8'hFF);
    rdchk(ADDR_STATUS, 8'h44);
    $display("t_src done");
  endtask
  task automatic t_opts;
    wr(ADDR_OPT1, 8'h2C);
    rdchk(ADDR_OPT1, 8'h20);
    wr(ADDR_OPT1, 8'hC0);
    rdchk(ADDR_OPT1, 8'h20);
    chk({6'h00, stop_mode_allowed, watchdog_running}, 8'h02);
    {stop_executed, background_executed, background_mode_enable} = 3'h7;
    {low_voltage_trip, low_voltage_reset_enable} = 2'b10;
    wr(ADDR_FORCE, 8'h01);
    {stop_executed, background_executed, background_mode_enable} = 3'h0;
    {low_voltage_trip, low_voltage_reset_enable} = 2'b01;
    wait_rst(8, n);
    chk(8'(n), 8'h08);
    rdchk(ADDR_STATUS, 8'h44);
    u_debug_host.send(ADDR_FORCE, 8'h01);
    wait_rst(8, n);
    chk(8'(n), 8'h00);
    rdchk(ADDR_STATUS, 8'h00);
    rdchk(ADDR_OPT1, OPT1_RESET);
    $display("t_opts done");
  endtask
  task automatic t_wd(input logic [7:0] o2, input int lo);
    wr(ADDR_OPT2, o2);
    rdchk(ADDR_OPT2, o2);
    wr(ADDR_OPT1, 8'h40);
    wr(ADDR_STATUS, 8'h00);
    wait_rst(2000, n);
    chk(8'(n >= lo - 6 && n <= lo + 4), 8'h01);
    rdchk(ADDR_STATUS, 8'h20);
    $display("t_wd done");
  endtask
  task automatic t_win;
    wr(ADDR_OPT2, 8'hC0);
    wr(ADDR_OPT1, 8'h40);
    // early key write; the reset it causes stands for one cycle only
    reg_wr = 1'b1;
    reg_addr = ADDR_STATUS;
    reg_wdata = WIN_KEY_FIRST;
    tick(1);
    reg_wr = 1'b0;
    wait_rst(4, n);
    chk(8'(n), 8'h00);
    rdchk(ADDR_STATUS, 8'h20);
    wr(ADDR_OPT2, 8'hC0);
    wr(ADDR_OPT1, 8'h40);
    tick(WIN1);
    wr(ADDR_STATUS, WIN_KEY_FIRST);
    wr(ADDR_STATUS, WIN_KEY_SECOND);
    wait_rst(40, n);
    chk(8'(n), 8'h28);
    $display("t_win done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      final_report;
    end
  end
  initial
  begin
    tick(16);
    rst = 1'b0;
    tick(1);
    t_por;
    t_src;
    t_opts;
    t_wd(8'h80, OVF1);
    t_wd(8'h00, 32 * DIV);
    t_win;
    final_report;
  end
endmodule // tb_top
